// >>> pix_port_consts.vh
`ifndef PIX_PORT_CONSTS_VH
`define PIX_PORT_CONSTS_VH

// ****************************************
// Register map (APB byte offsets)
// ****************************************
`define REG_CTRL        12'h000
`define REG_GPIO_OUT    12'h004
`define REG_GPIO_OE     12'h008
`define REG_STATUS      12'h00C
`define REG_GPIO_IN     12'h010

// ****************************************
// Control register fields
// ****************************************
`define CTRL_MODE16     0
`define CTRL_OUT_DIS    1
`define CTRL_TS_SEL_LO  2
`define CTRL_TS_SEL_HI  3
`define CTRL_ACT_HONLY  4
`define CTRL_ACT_AND_V  5
`define CTRL_TEST       6
`define CTRL_DVCLK_MST  7
`define CTRL_RESET      8'h00

// ****************************************
// Tristate group select codes
// ****************************************
`define TS_DATA         2'h0
`define TS_TIMING       2'h1
`define TS_CLOCKS       2'h2
`define TS_ALL          2'h3

// ****************************************
// Timing generator defaults
// ****************************************
`define H_TOTAL         12'h35A
`define H_ACTIVE        12'h2D0
`define H_SYNC          12'h040
`define V_TOTAL         10'h106
`define V_ACTIVE        10'h0F0
`define V_SYNC          10'h003
`define BLANK_Y         8'h10
`define BLANK_C         8'h80

`endif

// >>> pix_timing.v
`timescale 1ns/1ns
`default_nettype none
`include "pix_port_consts.vh"

// Raster counters; advance once per pixel tick
module pix_timing #(
  parameter H_TOTAL = `H_TOTAL,
  parameter H_ACT   = `H_ACTIVE,
  parameter H_SYNC  = `H_SYNC,
  parameter V_TOTAL = `V_TOTAL,
  parameter V_ACT   = `V_ACTIVE,
  parameter V_SYNC  = `V_SYNC
) (
  input  wire        sys_clk_in,
  input  wire        srst_in,
  input  wire        ce_in,
  input  wire        tick_in,
  output reg  [11:0] hcnt_out,
  output reg  [9:0]  vcnt_out,
  output reg         even_field_out,
  output wire        h_act_out,
  output wire        v_act_out,
  output wire        h_sync_out,
  output wire        v_sync_out
);
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      hcnt_out       <= 12'h000;
      vcnt_out       <= 10'h000;
      even_field_out <= 1'b0;
    end else if (ce_in && tick_in) begin
      if (hcnt_out == H_TOTAL - 1) begin
        hcnt_out <= 12'h000;
        if (vcnt_out == V_TOTAL - 1) begin
          vcnt_out       <= 10'h000;
          even_field_out <= ~even_field_out;
        end else begin
          vcnt_out <= vcnt_out + 10'h001;
        end
      end else begin
        hcnt_out <= hcnt_out + 12'h001;
      end
    end
  end

  assign h_act_out  = hcnt_out < H_ACT;
  assign v_act_out  = vcnt_out < V_ACT;
  assign h_sync_out = hcnt_out >= H_TOTAL - H_SYNC;
  assign v_sync_out = vcnt_out >= V_TOTAL - V_SYNC;
endmodule // pix_timing

`default_nettype wire

// >>> video_pixel_output_port.v
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pix_port_consts.vh"

// How it works
// (R1) 16-bit: luma on upper byte
// (R2) 8-bit: chroma/luma stream on upper byte
// (R3) 16-bit: alternating Cr/Cb on lower byte
// (R4) 8-bit: lower byte released as input
// (R5) Test mode: lower byte looped to upper
// (R6) General pins released after reset
// (R7) Pin or register bit tristates chosen group
// (R8) Half-rate clock is full clock halved
// (R9) Line reset strobe active low
// (R10) Field reset strobe active low
// (R11) Active marks non-blank, optionally horizontal only
// (R12) Vertical active over non-blank lines
// (R13) Valid marks pixels; optionally ANDed into active
// (R14) Qualifier clock from inverted phase or inverted full clock
// (R15) Open-drain caption flag while queue holds data
// (R16) Source holds unused digital resets fixed
// (R17) Digital clock pin input or output
// (R18) 8-bit: chroma first, luma next clock
// (R19) All pixels incl. blanking synchronous to clock
// (R20) Field high for even fields
// (R21) Cb flag only on Cb sample periods
module video_pixel_output_port (
  input  wire        sys_clk_in,
  input  wire        srst_in,
  input  wire        ce_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire [7:0]  luma_in,
  input  wire [7:0]  chroma_in,
  input  wire        pix_valid_in,
  input  wire        caption_pending_in,
  input  wire        out_enable_pin_n_in,
  input  wire [7:0]  pix_data_lo_in,
  output reg  [7:0]  pix_data_hi_out,
  output reg         pix_data_hi_oe_out,
  output reg  [7:0]  pix_data_lo_out,
  output reg         pix_data_lo_oe_out,
  input  wire [7:0]  general_io_pins_in,
  output reg  [7:0]  general_io_pins_out,
  output reg  [7:0]  general_io_pins_oe_out,
  output reg         sample_clk_full_out,
  output reg         sample_clk_half_out,
  output reg         gated_qual_clk_out,
  output reg         clocks_oe_out,
  output reg         line_reset_n_out,
  output reg         field_reset_n_out,
  output reg         active_out,
  output reg         vert_active_out,
  output reg         valid_out,
  output reg         field_out,
  output reg         blue_chroma_flag_out,
  output reg         timing_oe_out,
  output reg         caption_ready_out,
  output reg         caption_ready_oe_out,
  input  wire        dvin_line_reset_n_in,
  input  wire        dvin_field_reset_n_in,
  input  wire        dvin_clk_in,
  output reg         dvin_clk_out,
  output reg         dvin_clk_oe_out,
  output reg  [7:0]  dvin_data_out,
  output reg         dvin_h_out,
  output reg         dvin_v_out
);
  // ****************************************
  // Registers and bus slave
  // ****************************************
  reg  [7:0]  ctrl;
  reg  [7:0]  gpio_dout;
  reg  [7:0]  gpio_oe;
  reg  [7:0]  gpio_sync;
  reg         phase;
  reg         cb_turn;
  reg  [7:0]  chroma_hold;
  reg  [31:0] next_rdata;
  reg         next_err;

  wire mode16   = ctrl[`CTRL_MODE16];
  wire test_on  = ctrl[`CTRL_TEST];
  wire [1:0] ts_sel = ctrl[`CTRL_TS_SEL_HI:`CTRL_TS_SEL_LO];
  wire bus_acc  = psel_in && penable_in && !pready_out;
  wire tick     = mode16 ? phase : 1'b1;
  wire [11:0] hcnt;
  wire [9:0]  vcnt;
  wire        even_fld;
  wire        h_act;
  wire        v_act;
  wire        h_sync;
  wire        v_sync;

  function group_off;
    input [1:0] sel;
    input [1:0] grp;
    begin
      group_off = (sel == `TS_ALL) || (sel == grp);
    end
  endfunction

  // Three-state request from either the pin or the register bit
  wire off_req = out_enable_pin_n_in || ctrl[`CTRL_OUT_DIS]; // R7

  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (paddr_in)
      `REG_CTRL:     next_rdata = {24'h000000, ctrl};
      `REG_GPIO_OUT: next_rdata = {24'h000000, gpio_dout};
      `REG_GPIO_OE:  next_rdata = {24'h000000, gpio_oe};
      `REG_STATUS:   next_rdata = {20'h00000, even_fld, v_act, h_act, caption_pending_in,
                                   vcnt[7:0]};
      `REG_GPIO_IN:  next_rdata = {24'h000000, gpio_sync};
      default:       next_err   = 1'b1;
    endcase
  end

  // One wait state: pready rises the cycle after the access phase starts
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl        <= `CTRL_RESET;
      gpio_dout   <= 8'h00;
      gpio_oe     <= 8'h00; // R6
      gpio_sync   <= 8'h00;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else if (ce_in) begin
      gpio_sync  <= general_io_pins_in;
      pready_out <= bus_acc;
      if (bus_acc) begin
        pslverr_out <= next_err;
        prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
        if (pwrite_in) begin
          case (paddr_in)
            `REG_CTRL:     ctrl      <= pwdata_in[7:0];
            `REG_GPIO_OUT: gpio_dout <= pwdata_in[7:0];
            `REG_GPIO_OE:  gpio_oe   <= pwdata_in[7:0]; // R6
            default:       ctrl      <= ctrl;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Raster timing
  // ****************************************
  pix_timing u_timing (
    .sys_clk_in     (sys_clk_in),
    .srst_in        (srst_in),
    .ce_in          (ce_in),
    .tick_in        (tick),
    .hcnt_out       (hcnt),
    .vcnt_out       (vcnt),
    .even_field_out (even_fld),
    .h_act_out      (h_act),
    .v_act_out      (v_act),
    .h_sync_out     (h_sync),
    .v_sync_out     (v_sync)
  );

  wire blank     = !(h_act && v_act);
  wire [7:0] y_s = blank ? `BLANK_Y : luma_in;
  wire [7:0] c_s = blank ? `BLANK_C : chroma_in;
  wire act_raw   = ctrl[`CTRL_ACT_HONLY] ? h_act : (h_act && v_act); // R11
  wire vld       = pix_valid_in && h_act && v_act;

  // ****************************************
  // Pixel and flag outputs
  // ****************************************
  // Everything is registered on the system clock, so data, flags and the
  // derived clocks keep a fixed phase; dvin_clk_out is a one-cycle-late copy of the full clock.
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      phase                  <= 1'b0;
      cb_turn                <= 1'b1;
      chroma_hold            <= `BLANK_C;
      sample_clk_full_out    <= 1'b0;
      sample_clk_half_out    <= 1'b0;
      gated_qual_clk_out     <= 1'b0;
      pix_data_hi_out        <= 8'h00;
      pix_data_lo_out        <= 8'h00;
      pix_data_hi_oe_out     <= 1'b0;
      pix_data_lo_oe_out     <= 1'b0;
      clocks_oe_out          <= 1'b0;
      timing_oe_out          <= 1'b0;
      line_reset_n_out       <= 1'b1;
      field_reset_n_out      <= 1'b1;
      active_out             <= 1'b0;
      vert_active_out        <= 1'b0;
      valid_out              <= 1'b0;
      field_out              <= 1'b0;
      blue_chroma_flag_out   <= 1'b0;
      caption_ready_out      <= 1'b0;
      caption_ready_oe_out   <= 1'b0;
      general_io_pins_out    <= 8'h00;
      general_io_pins_oe_out <= 8'h00; // R6
      dvin_clk_out           <= 1'b0;
      dvin_clk_oe_out        <= 1'b0;
      dvin_data_out          <= 8'h00;
      dvin_h_out             <= 1'b1;
      dvin_v_out             <= 1'b1;
    end else if (ce_in) begin
      phase               <= ~phase;
      sample_clk_full_out <= ~sample_clk_full_out;
      // Toggle on every second enabled cycle so the period is twice the full clock
      if (phase)
        sample_clk_half_out <= ~sample_clk_half_out; // R8
      // Qualifier is gated by valid so capture logic only clocks real pixels
      gated_qual_clk_out  <= vld && (mode16 ? !phase : !sample_clk_full_out); // R14
      if (tick) begin // R19
        if (mode16) begin
          pix_data_hi_out <= y_s; // R1
          pix_data_lo_out <= c_s; // R3
          blue_chroma_flag_out <= cb_turn; // R21
          cb_turn         <= ~cb_turn;
        end else if (!sample_clk_full_out) begin
          pix_data_hi_out      <= c_s; // R2 R18
          chroma_hold          <= y_s;
          blue_chroma_flag_out <= cb_turn; // R21
          cb_turn              <= ~cb_turn;
        end else begin
          pix_data_hi_out      <= chroma_hold; // R18
          blue_chroma_flag_out <= 1'b0;
        end
        if (test_on)
          pix_data_hi_out <= pix_data_lo_in; // R5
        line_reset_n_out  <= !h_sync; // R9
        field_reset_n_out <= !v_sync; // R10
        vert_active_out   <= v_act; // R12
        valid_out         <= vld; // R13
        active_out        <= ctrl[`CTRL_ACT_AND_V] ? (act_raw && vld) : act_raw; // R13
        field_out         <= even_fld; // R20
      end
      pix_data_hi_oe_out <= !(off_req && group_off(ts_sel, `TS_DATA)); // R7
      pix_data_lo_oe_out <= mode16 && !test_on &&
                            !(off_req && group_off(ts_sel, `TS_DATA)); // R4 R7
      timing_oe_out      <= !(off_req && group_off(ts_sel, `TS_TIMING)); // R7
      clocks_oe_out      <= !(off_req && group_off(ts_sel, `TS_CLOCKS)); // R7
      caption_ready_out    <= 1'b0;
      caption_ready_oe_out <= caption_pending_in; // R15
      general_io_pins_out    <= gpio_dout;
      general_io_pins_oe_out <= gpio_oe;
      dvin_clk_oe_out <= ctrl[`CTRL_DVCLK_MST]; // R17
      dvin_clk_out    <= sample_clk_full_out; // R17
      // Digital input capture; resets sampled as plain levels
      dvin_data_out <= pix_data_lo_in; // R4
      dvin_h_out    <= dvin_line_reset_n_in; // R16
      dvin_v_out    <= dvin_field_reset_n_in; // R16
    end
  end

  // Slave-mode digital clock is left unused; no second domain
  wire unused_dvclk = dvin_clk_in;
endmodule // video_pixel_output_port

`default_nettype wire

// >>> pix_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pix_port_checker(
  input wire logic sys_clk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pix_data_hi_oe_out, pix_data_lo_oe_out, clocks_oe_out, timing_oe_out,
  input wire logic out_enable_pin_n_in, sample_clk_full_out, sample_clk_half_out,
  input wire logic caption_pending_in, caption_ready_oe_out, dvin_clk_oe_out,
  input wire logic [7:0] general_io_pins_oe_out
);
  logic [7:0] ctrl;
  // Shadow of the control word; the repeats below allow for its register lag
  always @(posedge sys_clk_in)
    if (srst_in) ctrl <= 8'h00;
    else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000)
      ctrl <= pwdata_in[7:0];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  property p_apb; psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out; endproperty
  property p_gpio; $past(srst_in) |-> general_io_pins_oe_out == 8'h00; endproperty
  property p_lo8; (!ctrl[0]) [*3] |-> !pix_data_lo_oe_out; endproperty
  property p_tri; ((out_enable_pin_n_in || ctrl[1]) && ctrl[3:2] == 2'h3) [*3] |->
    !(pix_data_hi_oe_out || pix_data_lo_oe_out || clocks_oe_out || timing_oe_out); endproperty
  property p_full; !$past(srst_in) && !$past(srst_in, 2) |-> $changed(sample_clk_full_out);
  endproperty
  property p_half; $changed(sample_clk_half_out) |=>
    $stable(sample_clk_half_out) ##1 $changed(sample_clk_half_out); endproperty
  property p_cap; $stable(caption_pending_in) [*3] |-> $stable(caption_ready_oe_out); endproperty
  property p_dvclk; (!ctrl[7]) [*3] |-> !dvin_clk_oe_out; endproperty
  a_apb: assert property (p_apb) else $error("bus answer late or long");
  a_gpio: assert property (p_gpio) else $error("general pins driven after reset");
  a_lo8: assert property (p_lo8) else $error("lower byte driven in 8-bit mode");
  a_tri: assert property (p_tri) else $error("group not three-stated");
  a_full: assert property (p_full) else $error("full clock stuck");
  a_half: assert property (p_half) else $error("half clock wrong rate");
  a_cap: assert property (p_cap) else $error("caption flag moved alone");
  a_dvclk: assert property (p_dvclk) else $error("video clock driven as slave");
  c_m16: cover property (ctrl[0] && pix_data_lo_oe_out);
  c_wr: cover property (pready_out && pwrite_in);
  c_mst: cover property ($rose(dvin_clk_oe_out));
endmodule // pix_port_checker
bind video_pixel_output_port pix_port_checker u_chk(.*);
`default_nettype wire

// >>> frame_capture_model.sv
`timescale 1ns/1ns
`default_nettype none
module frame_capture_model(
  input wire logic sys_clk_in, clr_in, pix_data_hi_oe_out, pix_data_lo_oe_out,
  input wire logic [7:0] pix_data_hi_out, pix_data_lo_out,
  output logic [7:0] pix_data_lo_in,
  output logic [255:0] seen_hi, seen_lo
);
  logic [7:0] pat = 8'h00;
  // Our video source changes every cycle so a stale echo cannot pass
  assign pix_data_lo_in = pix_data_lo_oe_out ? pix_data_lo_out : pat;
  always @(posedge sys_clk_in) begin
    pat <= pat + 8'h01;
    if (clr_in) begin
      seen_hi <= '0;
      seen_lo <= '0;
    end else begin
      if (pix_data_hi_oe_out) seen_hi[pix_data_hi_out] <= 1'h1;
      if (pix_data_lo_oe_out) seen_lo[pix_data_lo_out] <= 1'h1;
    end
  end
endmodule // frame_capture_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk_in, srst_in, ce_in, psel_in, penable_in, pwrite_in, pix_valid_in, clr_in, er;
  logic caption_pending_in, out_enable_pin_n_in, dvin_line_reset_n_in, dvin_field_reset_n_in, dvin_clk_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [7:0] luma_in, chroma_in, general_io_pins_in, pix_data_lo_in, pix_data_hi_out;
  logic [7:0] pix_data_lo_out, general_io_pins_out, general_io_pins_oe_out, dvin_data_out;
  logic pready_out, pslverr_out, pix_data_hi_oe_out, pix_data_lo_oe_out, sample_clk_full_out;
  logic sample_clk_half_out, gated_qual_clk_out, clocks_oe_out, line_reset_n_out, oe_a;
  logic field_reset_n_out, active_out, vert_active_out, valid_out, field_out, timing_oe_out;
  logic blue_chroma_flag_out, caption_ready_out, caption_ready_oe_out, dvin_clk_out;
  logic dvin_clk_oe_out, dvin_h_out, dvin_v_out;
  logic [255:0] seen_hi, seen_lo;
  int n_errors, n_tests, cyc;
  video_pixel_output_port u_dut(.*);
  frame_capture_model u_fb(.*);
  initial begin
    sys_clk_in = 0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      finish_test();
    end
  end
  task chk(input logic [31:0] g, x);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task finish_test;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wt(int n); repeat (n) @(posedge sys_clk_in); endtask
  task clr; clr_in <= 1; wt(1); clr_in <= 0; endtask
  function logic [255:0] m2(logic [7:0] a, b); m2 = '0; m2[a] = 1; m2[b] = 1; endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    wt(1); psel_in <= 1; penable_in <= 0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    wt(1); penable_in <= 1;
    do wt(1); while (pready_out !== 1'h1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 0; penable_in <= 0;
  endtask
  task t_flags;
    int nl, na, nv, nc, nq;
    nl = 0; na = 0; nv = 0; nc = 0; nq = 0;
    apb(1, 12'h000, 32'h10); wt(4);
    for (int i = 0; i < 858; i++) begin
      wt(1);
      nl += !line_reset_n_out;
      na += active_out;
      nv += valid_out;
      nq += gated_qual_clk_out;
      if (i < 856) nc += blue_chroma_flag_out;
    end
    chk(nl, 64);
    chk(na, 720);
    chk(nv, 720);
    chk(nq, 360);
    chk(nc, 214);
    chk(vert_active_out, 1);
    chk(field_reset_n_out, 1);
    chk(field_out, 0);
  endtask
  task t_regs;
    chk(general_io_pins_oe_out, 8'h00);
    apb(1, 12'h008, 32'hFF); apb(1, 12'h004, 32'hC3); wt(3);
    chk(general_io_pins_oe_out, 8'hFF);
    chk(general_io_pins_out, 8'hC3);
    apb(0, 12'h010, 0); chk(rd[7:0], 8'h96);
    apb(0, 12'h020, 0); chk(er, 1'h1); chk(rd, 32'h0);
  endtask
  task t_mode16;
    apb(1, 12'h000, 32'h1); wt(4); clr; wt(3000);
    chk(|(seen_hi & ~m2(8'h5A, 8'h10)), 0);
    chk(|seen_hi, 1);
    chk(|(seen_lo & ~m2(8'hA5, 8'h80)), 0);
    chk(pix_data_lo_oe_out, 1);
  endtask
  task t_mode8;
    apb(1, 12'h000, 32'h0); wt(4); clr; wt(3000);
    chk(|(seen_hi & ~(m2(8'h5A, 8'h10) | m2(8'hA5, 8'h80))), 0);
    chk(seen_hi[8'hA5] | seen_hi[8'h80], 1);
    chk(seen_hi[8'h5A] | seen_hi[8'h10], 1);
    chk(pix_data_lo_oe_out, 0);
    chk(|seen_lo, 0);
  endtask
  task t_test;
    apb(1, 12'h000, 32'h40); wt(4); clr; wt(600);
    chk(pix_data_lo_oe_out, 0);
    chk(seen_hi[8'h3C] | seen_hi[8'h3D], 1);
  endtask
  task t_tri;
    apb(1, 12'h000, 32'hD); out_enable_pin_n_in <= 1; wt(4);
    chk({pix_data_hi_oe_out, pix_data_lo_oe_out, clocks_oe_out, timing_oe_out}, 0);
    out_enable_pin_n_in <= 0; apb(1, 12'h000, 32'hF); wt(4);
    chk({pix_data_hi_oe_out, pix_data_lo_oe_out, clocks_oe_out, timing_oe_out}, 0);
    apb(1, 12'h000, 32'h5); out_enable_pin_n_in <= 1; wt(4);
    chk({pix_data_hi_oe_out, timing_oe_out}, 2'h2);
    out_enable_pin_n_in <= 0;
  endtask
  task t_misc;
    caption_pending_in <= 1; wt(4); oe_a = caption_ready_oe_out;
    caption_pending_in <= 0; wt(4);
    chk(oe_a, 1);
    chk(caption_ready_oe_out, 0);
    chk(caption_ready_out, 0);
    apb(1, 12'h000, 32'h80); wt(4); chk(dvin_clk_oe_out, 1);
    apb(1, 12'h000, 32'h0); wt(4); chk(dvin_clk_oe_out, 0);
  endtask
  initial begin
    srst_in = 1; ce_in = 1; psel_in = 0; penable_in = 0; pwrite_in = 0; paddr_in = 0;
    pwdata_in = 0; luma_in = 8'h5A; chroma_in = 8'hA5; pix_valid_in = 1; clr_in = 0;
    caption_pending_in = 0; out_enable_pin_n_in = 0; general_io_pins_in = 8'h96;
    dvin_line_reset_n_in = 1; dvin_field_reset_n_in = 1; dvin_clk_in = 0;
    wt(12); srst_in <= 0; wt(1);
    t_regs; t_mode16; t_mode8; t_test; t_tri; t_misc; t_flags;
    finish_test;
  end
endmodule // tb
`default_nettype wire
